// file: design/qdac_pkg.sv
/*
 Constants shared by the quad converter serial load block: frame
 layout, register offsets, reset values and bus response codes.
 Assumes a 32-bit AXI4-Lite register bus with 6 address bits.
*/
package qdac_pkg;
	////////////////////////////////////////////////////////////////////
	// Serial frame layout
	localparam int FRAME_W  = 14;          // Bits in one frame
	localparam int CODE_W   = 10;          // Converter code width
	localparam int N_CH     = 4;           // Channels A to D
	localparam int ALL_OFF_BIT = 13;       // all_channel_shutdown
	localparam int ONE_OFF_BIT = 12;       // single_channel_shutdown
	localparam int SEL_HI   = 11;          // channel_sel_hi
	localparam int SEL_LO   = 10;          // channel_sel_lo
	localparam int CODE_MSB = 9;           // code_msb, code_lsb is 0
	localparam int CNT_W    = 5;           // Frame bit counter width
	localparam logic [CNT_W-1:0] CNT_MAX = 5'h1f;
	////////////////////////////////////////////////////////////////////
	// Pin bundle indices and idle levels
	localparam int PIN_W    = 5;
	localparam int P_CLK    = 4;
	localparam int P_SELN   = 3;
	localparam int P_DATA   = 2;
	localparam int P_LOADN  = 1;
	localparam int P_CLRN   = 0;
	localparam logic [PIN_W-1:0] PIN_IDLE = 5'h0b;
	////////////////////////////////////////////////////////////////////
	// Register map (byte addresses)
	localparam int AXI_AW = 6;
	localparam logic [3:0] OFS_CTRL   = 4'h0;  // 0x00
	localparam logic [3:0] OFS_STATUS = 4'h1;  // 0x04
	localparam logic [3:0] OFS_SHIFT  = 4'h2;  // 0x08
	localparam logic [1:0] GRP_INPUT  = 2'h1;  // 0x10..0x1c
	localparam logic [1:0] GRP_DAC    = 2'h2;  // 0x20..0x2c
	localparam int CTRL_EN_BIT  = 0;           // Serial link enable
	localparam logic CTRL_EN_RST = 1'b1;
	localparam int ST_SEL_BIT   = 8;           // Select currently low
	localparam int ST_CNT_LSB   = 16;          // Bits in current frame
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: design/qdac_sync.sv
/*
 Two-stage synchroniser for a bundle of asynchronous pin levels.
 Assumes each bit is an independent level; no bus coherence.
*/
`timescale 1ns/100ps
module qdac_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input  wire logic         clk,
	input  wire logic         srst,
	input  wire logic         ce,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta;   // First stage, read only by second stage

	// Both stages reset to the idle pin levels
	always_ff @(posedge clk) begin
		if (srst) begin
			meta <= RST_VAL;
			q    <= RST_VAL;
		end else if (ce) begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule

// file: design/qdac_serial_load.sv
/*
 Serial write path and register control of a quad voltage-output
 converter, with an AXI4-Lite slave for control and readback.
 Assumes all serial pins are asynchronous to MCLK and that the serial
 clock runs well below MCLK/4 so each level is seen several times.
*/
// Behaviour
// - Shift serial_in on selected serial clock rise
// - Select high freezes the shift register
// - Select rise copies frame to addressed input
// - Select never affects the load strobe
// - Load low makes DAC registers follow inputs
// - Load acts on its level, not serial clock
// - Clear zeroes all input and DAC registers
// - Clear leaves the shift register untouched
// - Frame is MSB first with fixed fields
// - Decode shutdown flags and channel address
// - Reset zeroes input and DAC registers
// - Writes accepted while a channel is shutdown
`timescale 1ns/100ps
module qdac_serial_load (
	input  wire logic                        MCLK,
	input  wire logic                        SRST,
	input  wire logic                        CE,
	input  wire logic                        SERIAL_CLK,
	input  wire logic                        SELECT_N,
	input  wire logic                        SERIAL_IN,
	input  wire logic                        DAC_LOAD_STROBE_N,
	input  wire logic                        REGISTER_CLEAR_N,
	output logic [qdac_pkg::CODE_W-1:0]      DAC_CODE_A,
	output logic [qdac_pkg::CODE_W-1:0]      DAC_CODE_B,
	output logic [qdac_pkg::CODE_W-1:0]      DAC_CODE_C,
	output logic [qdac_pkg::CODE_W-1:0]      DAC_CODE_D,
	output logic [qdac_pkg::N_CH-1:0]        SHUTDOWN,
	input  wire logic [qdac_pkg::AXI_AW-1:0] S_AXI_AWADDR,
	input  wire logic                        S_AXI_AWVALID,
	output logic                             S_AXI_AWREADY,
	input  wire logic [31:0]                 S_AXI_WDATA,
	input  wire logic [3:0]                  S_AXI_WSTRB,
	input  wire logic                        S_AXI_WVALID,
	output logic                             S_AXI_WREADY,
	output logic [1:0]                       S_AXI_BRESP,
	output logic                             S_AXI_BVALID,
	input  wire logic                        S_AXI_BREADY,
	input  wire logic [qdac_pkg::AXI_AW-1:0] S_AXI_ARADDR,
	input  wire logic                        S_AXI_ARVALID,
	output logic                             S_AXI_ARREADY,
	output logic [31:0]                      S_AXI_RDATA,
	output logic [1:0]                       S_AXI_RRESP,
	output logic                             S_AXI_RVALID,
	input  wire logic                        S_AXI_RREADY
);
	import qdac_pkg::*;

	////////////////////////////////////////////////////////////////////
	// Pin synchronisation and edge detection
	logic [PIN_W-1:0] pins;        // Synchronised pin levels
	logic             sclk_q;      // Serial clock one sample back
	logic             seln_q;      // Select one sample back
	logic             link_en;     // Serial link enable from CTRL
	logic             sclk_rise;   // Qualified serial clock rise
	logic             sel_rise;    // Select returned high
	logic             load_low;    // Load strobe asserted
	logic             clear_low;   // Register clear asserted

	qdac_sync #(.W(PIN_W), .RST_VAL(PIN_IDLE)) u_sync (
		.clk  (MCLK),
		.srst (SRST),
		.ce   (CE),
		.d    ({SERIAL_CLK, SELECT_N, SERIAL_IN,
		        DAC_LOAD_STROBE_N, REGISTER_CLEAR_N}),
		.q    (pins)
	);

	// Edges are found on the synchronised copies only
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			sclk_q <= 1'b0;
			seln_q <= 1'b1;
		end else if (CE) begin
			sclk_q <= pins[P_CLK];
			seln_q <= pins[P_SELN];
		end
	end

	// Select gates shifting; load and clear ignore select entirely
	assign sclk_rise = link_en & ~pins[P_SELN]
	                 & pins[P_CLK] & ~sclk_q;
	assign sel_rise  = link_en & pins[P_SELN] & ~seln_q;
	assign load_low  = ~pins[P_LOADN];
	assign clear_low = ~pins[P_CLRN];

	////////////////////////////////////////////////////////////////////
	// Shift, input, DAC and shutdown registers
	logic [FRAME_W-1:0]           shift, next_shift;   // Serial frame
	logic [N_CH-1:0][CODE_W-1:0]  in_reg, next_in;     // Input regs
	logic [N_CH-1:0][CODE_W-1:0]  dac, next_dac;       // DAC regs
	logic [N_CH-1:0]              shut, next_shut;     // Shutdown
	logic [CNT_W-1:0]             cnt, next_cnt;       // Frame bits
	logic [1:0]                   ch;                  // Frame address

	assign ch = shift[SEL_HI:SEL_LO];

	// Next state of the converter registers; clear has top priority
	always_comb begin
		next_shift = shift;
		next_in    = in_reg;
		next_dac   = dac;
		next_shut  = shut;
		next_cnt   = cnt;
		if (sclk_rise) begin
			// Only the last fourteen bits matter, so overlong frames
			// keep their tail, as the host is expected to send 14
			next_shift = {shift[FRAME_W-2:0], pins[P_DATA]};
			if (cnt != CNT_MAX)
				next_cnt = cnt + 5'h01;
		end
		if (sel_rise) begin
			next_cnt = '0;
			if (shift[ALL_OFF_BIT]) begin
				next_shut = '1;
			end else if (shift[ONE_OFF_BIT]) begin
				next_shut[ch] = 1'b1;
			end else begin
				// Input is written even in shutdown; a data write
				// brings the channel back out of shutdown
				next_in[ch] = shift[CODE_MSB:0];
				next_shut[ch] = 1'b0;
			end
		end
		if (load_low)
			next_dac = in_reg;
		if (clear_low) begin
			next_in  = '0;
			next_dac = '0;
		end
	end

	// Register the converter state; reset zeroes everything
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			shift  <= '0;
			in_reg <= '0;
			dac    <= '0;
			shut   <= '0;
			cnt    <= '0;
		end else if (CE) begin
			shift  <= next_shift;
			in_reg <= next_in;
			dac    <= next_dac;
			shut   <= next_shut;
			cnt    <= next_cnt;
		end
	end

	assign DAC_CODE_A = dac[0];
	assign DAC_CODE_B = dac[1];
	assign DAC_CODE_C = dac[2];
	assign DAC_CODE_D = dac[3];
	assign SHUTDOWN   = shut;

	////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave
	logic              aw_held, next_aw_held;   // Write address taken
	logic              w_held, next_w_held;     // Write data taken
	logic [3:0]        waddr, next_waddr;       // Word index of write
	logic [31:0]       wdata, next_wdata;       // Held write data
	logic [3:0]        wstrb, next_wstrb;       // Held byte enables
	logic              ctrl_en, next_ctrl_en;   // CTRL enable bit
	logic              next_awready, next_wready, next_arready;
	logic              next_bvalid, next_rvalid;
	logic [1:0]        next_bresp, next_rresp;
	logic [31:0]       next_rdata;
	logic [3:0]        raddr;                   // Word index of read

	assign link_en = ctrl_en;
	assign raddr   = S_AXI_ARADDR[5:2];

	// One write and one read in flight; answers are registered
	always_comb begin
		next_aw_held = aw_held;
		next_w_held  = w_held;
		next_waddr   = waddr;
		next_wdata   = wdata;
		next_wstrb   = wstrb;
		next_ctrl_en = ctrl_en;
		next_bvalid  = S_AXI_BVALID;
		next_bresp   = S_AXI_BRESP;
		next_rvalid  = S_AXI_RVALID;
		next_rresp   = S_AXI_RRESP;
		next_rdata   = S_AXI_RDATA;
		if (S_AXI_AWVALID && S_AXI_AWREADY) begin
			next_aw_held = 1'b1;
			next_waddr   = S_AXI_AWADDR[5:2];
		end
		if (S_AXI_WVALID && S_AXI_WREADY) begin
			next_w_held = 1'b1;
			next_wdata  = S_AXI_WDATA;
			next_wstrb  = S_AXI_WSTRB;
		end
		if (S_AXI_BVALID && S_AXI_BREADY)
			next_bvalid = 1'b0;
		// Perform the write once both halves are held
		if (aw_held && w_held && !S_AXI_BVALID) begin
			next_aw_held = 1'b0;
			next_w_held  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = RESP_OKAY;
			if (waddr == OFS_CTRL) begin
				if (wstrb[0])
					next_ctrl_en = wdata[CTRL_EN_BIT];
			end else if (waddr != OFS_STATUS && waddr != OFS_SHIFT
			             && waddr[3:2] != GRP_INPUT
			             && waddr[3:2] != GRP_DAC) begin
				// Read-only words ignore writes; holes answer error
				next_bresp = RESP_SLVERR;
			end
		end
		if (S_AXI_RVALID && S_AXI_RREADY)
			next_rvalid = 1'b0;
		if (S_AXI_ARVALID && S_AXI_ARREADY) begin
			next_rvalid = 1'b1;
			next_rresp  = RESP_OKAY;
			next_rdata  = '0;
			if (raddr == OFS_CTRL)
				next_rdata[CTRL_EN_BIT] = ctrl_en;
			else if (raddr == OFS_STATUS) begin
				next_rdata[N_CH-1:0]  = shut;
				next_rdata[ST_SEL_BIT] = ~pins[P_SELN];
				next_rdata[ST_CNT_LSB +: CNT_W] = cnt;
			end else if (raddr == OFS_SHIFT)
				next_rdata[FRAME_W-1:0] = shift;
			else if (raddr[3:2] == GRP_INPUT)
				next_rdata[CODE_W-1:0] = in_reg[raddr[1:0]];
			else if (raddr[3:2] == GRP_DAC)
				next_rdata[CODE_W-1:0] = dac[raddr[1:0]];
			else
				next_rresp = RESP_SLVERR;
		end
		next_awready = ~next_aw_held & ~next_bvalid;
		next_wready  = ~next_w_held & ~next_bvalid;
		next_arready = ~next_rvalid;
	end

	// Register the bus state; ready outputs rise after reset
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			waddr         <= '0;
			wdata         <= '0;
			wstrb         <= '0;
			ctrl_en       <= CTRL_EN_RST;
			S_AXI_AWREADY <= 1'b0;
			S_AXI_WREADY  <= 1'b0;
			S_AXI_ARREADY <= 1'b0;
			S_AXI_BVALID  <= 1'b0;
			S_AXI_BRESP   <= RESP_OKAY;
			S_AXI_RVALID  <= 1'b0;
			S_AXI_RRESP   <= RESP_OKAY;
			S_AXI_RDATA   <= '0;
		end else if (CE) begin
			aw_held       <= next_aw_held;
			w_held        <= next_w_held;
			waddr         <= next_waddr;
			wdata         <= next_wdata;
			wstrb         <= next_wstrb;
			ctrl_en       <= next_ctrl_en;
			S_AXI_AWREADY <= next_awready;
			S_AXI_WREADY  <= next_wready;
			S_AXI_ARREADY <= next_arready;
			S_AXI_BVALID  <= next_bvalid;
			S_AXI_BRESP   <= next_bresp;
			S_AXI_RVALID  <= next_rvalid;
			S_AXI_RRESP   <= next_rresp;
			S_AXI_RDATA   <= next_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (SRST);

	sequence s_data_write;
		CE && sel_rise && !clear_low
		&& !shift[ALL_OFF_BIT] && !shift[ONE_OFF_BIT];
	endsequence
	sequence s_load_held;
		(CE && load_low && !clear_low) [*2];
	endsequence

	a_shift_edge: assert property (CE && sclk_rise |=>
		shift == {$past(shift[FRAME_W-2:0]), $past(pins[P_DATA])})
		else $error("shift did not take serial data");
	a_shift_idle: assert property (pins[P_SELN] |=> $stable(shift))
		else $error("shift moved while deselected");
	a_input_load: assert property (s_data_write |=>
		in_reg[$past(ch)] == $past(shift[CODE_MSB:0]) && !shut[$past(ch)])
		else $error("input register not written on select rise");
	a_load_follow: assert property (s_load_held |=>
		dac == $past(in_reg))
		else $error("DAC registers not transparent under load");
	a_load_nosel: assert property (CE && load_low && !clear_low
		&& !pins[P_SELN] |=> dac == $past(in_reg))
		else $error("load ignored while selected");
	a_dac_latch: assert property (CE && !load_low && !clear_low
		|=> $stable(dac))
		else $error("DAC registers moved with load high");
	a_clear_zero: assert property (CE && clear_low |=>
		in_reg == '0 && dac == '0)
		else $error("clear left nonzero registers");
	a_clear_keep: assert property (CE && clear_low && !sclk_rise
		|=> $stable(shift))
		else $error("clear disturbed the shift register");
	a_all_down: assert property (CE && sel_rise && shift[ALL_OFF_BIT]
		|=> shut == '1)
		else $error("all-channel shutdown not applied");
	// Clear may zero the inputs in the same cycle, so it is excluded
	a_one_down: assert property (CE && sel_rise && !clear_low
		&& !shift[ALL_OFF_BIT] && shift[ONE_OFF_BIT]
		|=> shut[$past(ch)] && $stable(in_reg))
		else $error("single-channel shutdown wrong");
	a_reset_zero: assert property (disable iff (1'b0) SRST
		|=> in_reg == '0 && dac == '0)
		else $error("reset left nonzero registers");
endmodule

// file: verif/qdac_host_model.sv
/*
 Host model of the three-wire serial link of the quad converter.
 Assumes a free-running bench clock; the serial clock moves in frames and in idle_clocks.
*/
`timescale 1ns/100ps
module qdac_host_model (
	input  wire logic clk,   // Bench clock, 25 ns
	output logic      sclk,  // Serial clock, still outside frames except in idle_clocks
	output logic      sel_n, // Active-low select
	output logic      ser_data // Serial data
);
	localparam int HALF = 4; // Half of the 200 ns link period
	// Idle pin levels at time zero
	initial begin
		sclk = 1'b0;
		sel_n = 1'b1;
		ser_data = 1'b0;
	end
	////////////////////////////////////////////////////////////////////
	// Wait a number of bench clock edges
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Select, then shift the low n bits, most significant first
	task automatic shift(input logic [13:0] f, input int n);
		sel_n <= 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			ser_data <= f[i];
			tick(HALF);
			sclk <= 1'b1;
			tick(HALF);
			sclk <= 1'b0;
		end
		tick(HALF);
	endtask
	// End the frame; released data shows the inverse, never a stale bit
	task automatic close;
		sel_n <= 1'b1;
		ser_data <= ~ser_data;
		tick(8);
	endtask
	// Clock pulses while deselected, to prove they are ignored
	task automatic idle_clocks(input int n);
		repeat (n) begin
			sclk <= 1'b1;
			tick(HALF);
			sclk <= 1'b0;
			tick(HALF);
		end
	endtask
endmodule

// file: verif/qdac_serial_load_tb_top.sv
/*
 Self-checking bench of the quad converter serial load block.
 Assumes the host model drives the link and AXI4-Lite reaches the registers.
*/
`timescale 1ns/100ps
module qdac_serial_load_tb_top;
	import qdac_pkg::*;
	logic        MCLK, SRST, load_n, clr_n;        // Clock, reset, strobes
	wire logic   sclk, sel_n, ser_data;            // Serial link wires
	logic [9:0]  dac [N_CH];                       // DAC register outputs
	logic [3:0]  SHUTDOWN;                         // Shutdown outputs
	logic [5:0]  awaddr, araddr;                   // Bus addresses
	logic [31:0] wdata, S_AXI_RDATA;               // Bus data
	logic        awvalid, wvalid, bready, arvalid, rready;
	logic        S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID;
	logic        S_AXI_ARREADY, S_AXI_RVALID;
	logic [1:0]  S_AXI_BRESP, S_AXI_RRESP;
	logic [9:0]  exp_in [N_CH];                    // Expected input regs
	logic [13:0] exp_shift;                        // Expected shift reg
	logic [3:0]  exp_shut;                         // Expected shutdown
	int          miscompares, checks_done;
	qdac_serial_load u_qdac_serial_load (
		.MCLK(MCLK), .SRST(SRST), .CE(1'b1), .SERIAL_CLK(sclk),
		.SELECT_N(sel_n), .SERIAL_IN(ser_data), .DAC_LOAD_STROBE_N(load_n),
		.REGISTER_CLEAR_N(clr_n), .DAC_CODE_A(dac[0]), .DAC_CODE_B(dac[1]),
		.DAC_CODE_C(dac[2]), .DAC_CODE_D(dac[3]), .SHUTDOWN(SHUTDOWN),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
		.S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(wdata),
		.S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid),
		.S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
		.S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
		.S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
		.S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID),
		.S_AXI_RREADY(rready)
	);
	qdac_host_model u_qdac_host_model (
		.clk(MCLK), .sclk(sclk), .sel_n(sel_n), .ser_data(ser_data)
	);
	////////////////////////////////////////////////////////////////////
	// Free-running 40 MHz clock
	initial begin
		MCLK = 1'b0;
		forever #12.5 MCLK = ~MCLK;
	end
	// Compare and count
	task automatic chk(input string nm, input logic [31:0] e, g);
		checks_done++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge MCLK);
	endtask
	// Bus read; request held until taken, data taken with rvalid
	task automatic rd(input logic [5:0] a, output logic [31:0] d,
		output logic [1:0] r);
		int n;
		n = 0;
		@(posedge MCLK);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge MCLK);
			if (S_AXI_ARREADY === 1'b1) arvalid <= 1'b0;
			n++;
		end while (S_AXI_RVALID !== 1'b1 && n < 200);
		d = S_AXI_RDATA;
		r = S_AXI_RRESP;
		rready <= 1'b0;
		if (n >= 200) miscompares++;
	endtask
	// Bus write; address and data offered together, each released alone
	task automatic wr(input logic [5:0] a, input logic [31:0] d,
		output logic [1:0] r);
		int n;
		n = 0;
		@(posedge MCLK);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge MCLK);
			if (S_AXI_AWREADY === 1'b1) awvalid <= 1'b0;
			if (S_AXI_WREADY === 1'b1) wvalid <= 1'b0;
			n++;
		end while (S_AXI_BVALID !== 1'b1 && n < 200);
		r = S_AXI_BRESP;
		bready <= 1'b0;
		if (n >= 200) miscompares++;
	endtask
	// Reference decode of a frame that reached the input stage
	task automatic apply(input logic [13:0] f);
		if (f[ALL_OFF_BIT]) exp_shut = '1;
		else if (f[ONE_OFF_BIT]) exp_shut[f[SEL_HI:SEL_LO]] = 1'b1;
		else begin
			exp_in[f[SEL_HI:SEL_LO]] = f[CODE_MSB:0];
			exp_shut[f[SEL_HI:SEL_LO]] = 1'b0;
		end
	endtask
	task automatic send(input logic [13:0] f);
		u_qdac_host_model.shift(f, FRAME_W);
		u_qdac_host_model.close();
		exp_shift = f;
		apply(f);
	endtask
	// Read back every input register and the shift register; check shutdown pins
	task automatic check_regs;
		logic [31:0] d;
		logic [1:0]  r;
		for (int c = 0; c < N_CH; c++) begin
			rd(6'h10 + 6'(c * 4), d, r);
			chk("input register", exp_in[c], d);
		end
		rd(6'h08, d, r);
		chk("shift register", exp_shift, d);
		chk("shutdown", exp_shut, SHUTDOWN);
	endtask
	task automatic chk_dac(input logic [9:0] e [N_CH]);
		for (int c = 0; c < N_CH; c++) chk("dac code", e[c], dac[c]);
	endtask
	////////////////////////////////////////////////////////////////////
	// Reset state, control word and an unmapped offset
	task automatic t_reset;
		logic [31:0] d;
		logic [1:0]  r;
		for (int i = 0; i < 8; i++) begin
			rd(6'h10 + 6'(i / 4 * 16 + i % 4 * 4), d, r);
			chk("register after reset", 0, d);
		end
		chk_dac('{default: 10'h000});
		rd(6'h3c, d, r);
		chk("unmapped response", RESP_SLVERR, r);
		wr(6'h00, 32'h0, r);
		rd(6'h00, d, r);
		chk("control word", 32'h0, d);
		// Link disabled: a full frame must leave every register alone
		u_qdac_host_model.shift(14'h2fff, FRAME_W);
		u_qdac_host_model.close();
		check_regs();
		wr(6'h00, 32'h1, r);
		chk("write response", RESP_OKAY, r);
	endtask
	// One data frame per channel; DAC must not move without load
	task automatic t_frames;
		logic [9:0] code [N_CH];
		code = '{10'h3ff, 10'h001, 10'h2aa, 10'h155};
		for (int c = 0; c < N_CH; c++) begin
			send({2'b00, 2'(c), code[c]});
			check_regs();
		end
		chk_dac('{default: 10'h000});
	endtask
	// Level load copies all inputs, then DAC holds
	task automatic t_load;
		load_n <= 1'b0;
		cyc(8);
		chk_dac(exp_in);
		load_n <= 1'b1;
		cyc(4);
		send({4'h0, 10'h0f0});
		chk("dac a held", 10'h3ff, dac[0]);
	endtask
	// Shutdown frames and a write while shut down
	task automatic t_shutdown;
		send({2'b01, 2'd2, 10'h3c3});
		check_regs();
		send({2'b10, 2'd0, 10'h000});
		check_regs();
		send({4'b0001, 10'h111});
		check_regs();
	endtask
	// Partial frame survives a clear; load works while selected
	task automatic t_clear;
		logic [31:0] d;
		logic [1:0]  r;
		u_qdac_host_model.shift(14'h0035, 7);
		exp_shift = {exp_shift[6:0], 7'h35};
		// Mid-frame status: seven bits counted, select seen low
		rd(6'h04, d, r);
		chk("status", {11'h0, 5'd7, 7'h0, 1'b1, 4'h0, exp_shut}, d);
		load_n <= 1'b0;
		cyc(8);
		chk_dac(exp_in);
		load_n <= 1'b1;
		clr_n <= 1'b0;
		cyc(8);
		exp_in = '{default: 10'h000};
		chk_dac(exp_in);
		check_regs();
		clr_n <= 1'b1;
		cyc(4);
		u_qdac_host_model.close();
		apply(exp_shift);
		check_regs();
		u_qdac_host_model.idle_clocks(3);
		check_regs();
	endtask
	////////////////////////////////////////////////////////////////////
	// Verdict and end of run
	task automatic test_done;
		if (miscompares == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// Watchdog well beyond the expected 1500 or so cycles
	initial begin
		repeat (40000) @(posedge MCLK);
		miscompares++;
		test_done();
	end
	// Main sequence
	initial begin
		{SRST, load_n, clr_n} = 3'b111;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		{awaddr, araddr, wdata} = '0;
		exp_in = '{default: 10'h000};
		exp_shift = '0;
		exp_shut = '0;
		miscompares = 0;
		checks_done = 0;
		cyc(2);
		SRST <= 1'b0;
		cyc(2);
		t_reset();
		t_frames();
		t_load();
		t_shutdown();
		t_clear();
		test_done();
	end
endmodule
